// *** tb/core_seq_model.sv ***
/*
  Core sequencer model: takes each vector request after a set delay.
  Assumes the block's clock and active-low reset.
*/
`timescale 1ns/1ns
`default_nettype none
module core_seq_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       vec_req,
  input  wire logic [3:0] ack_dly,
  output var  logic       vec_ack
);
  logic [3:0] wait_reg;
  // One ack per request; the delay lets the bench make the core slow
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_reg <= 4'h0;
      vec_ack  <= 1'b0;
    end else if (vec_req && !vec_ack) begin
      wait_reg <= wait_reg + 4'h1;
      vec_ack  <= (wait_reg >= ack_dly);
    end else begin
      wait_reg <= 4'h0;
      vec_ack  <= 1'b0;
    end
  end
endmodule : core_seq_model
`default_nettype wire

// *** tb/two_level_interrupt_vectoring_test.sv ***
/*
  Self-checking bench for the vectoring block: APB master, events and a
  reference of enables and vectors. Assumes the core sequencer model.
*/
`timescale 1ns/1ns
`default_nettype none
module two_level_interrupt_vectoring_test;
  import irq_vec_pkg::*;
  logic        pclk, presetn, clk_en, psel, penable, pwrite;
  logic [7:0]  paddr, src_event;
  logic [31:0] pwdata, prdata, rdata;
  logic        pready, pslverr, rerr, vec_ack, handler_return, vec_req;
  logic [20:0] core_pc, vec_addr, ret_push;
  logic        in_hi, in_lo;
  logic [3:0]  ack_dly;
  int          fail_count, samples_checked;

  irq_vectoring #(.N(NSRC)) dut_u (.pclk(pclk), .presetn(presetn),
    .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .src_event(src_event), .core_pc(core_pc),
    .vec_ack(vec_ack), .handler_return(handler_return),
    .vec_req(vec_req), .vec_addr(vec_addr), .ret_push(ret_push),
    .in_high_handler(in_hi), .in_low_handler(in_lo));
  core_seq_model core_u (.pclk(pclk), .presetn(presetn),
    .vec_req(vec_req), .ack_dly(ack_dly), .vec_ack(vec_ack));

  // Free-running 50 MHz clock
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // One transfer; an idle edge follows so psel never toggles twice at once
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the slave
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdata = prdata;
    rerr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdata, exp);
  endtask : rd_chk

  task automatic pulse(input int s);
    src_event[s] <= 1'b1;
    @(posedge pclk);
    src_event[s] <= 1'b0;
  endtask : pulse

  // Waits for a vector and lets the core model take it
  task automatic take(input logic [20:0] va);
    int n;
    n = 0;
    while (vec_req !== 1'b1 && n < 40) begin
      @(posedge pclk);
      n++;
    end
    chk({31'h0, vec_req}, 32'h1);
    chk(32'(vec_addr), 32'(va));
    chk(32'(ret_push), 32'(core_pc));
    n = 0;
    while (vec_req !== 1'b0 && n < 40) begin
      @(posedge pclk);
      n++;
    end
    chk({31'h0, vec_req}, 32'h0);
  endtask : take

  task automatic ret_h;
    handler_return <= 1'b1;
    @(posedge pclk);
    handler_return <= 1'b0;
    @(posedge pclk);
  endtask : ret_h

  task automatic close_out;
    $display("Counts: %0d checked, %0d mismatched", samples_checked,
             fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : close_out

  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    close_out();
  end

  initial begin
    int n, m, s, p;
    logic lo;
    {psel, penable, pwrite, paddr, pwdata, src_event} = 51'h0;
    {handler_return, core_pc, ack_dly, presetn} = 27'h0;
    clk_en = 1'b1;
    fail_count = 0;
    samples_checked = 0;
    void'($urandom(2888));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd_chk(ADDR_IRQ_CTRL, 32'h0);
    rd_chk(ADDR_RESET_CTRL, 32'h0);
    rd_chk(ADDR_ENABLES, {24'h0, RST_ENABLES});
    rd_chk(ADDR_PRIORITY, {24'h0, RST_PRIORITY});
    rd_chk(8'h18, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    $display("Done: reset values");
    // Flag sets with everything disabled and can be polled
    pulse(4);
    repeat (4) @(posedge pclk);
    chk({31'h0, vec_req}, 32'h0);
    rd_chk(ADDR_FLAGS, 32'h10);
    // Peripheral needs bit 6 too in compatibility mode
    wr_blk: begin
      apb(1'b1, ADDR_ENABLES, 32'h10);
      apb(1'b1, ADDR_IRQ_CTRL, 32'h80);
    end
    repeat (5) @(posedge pclk);
    chk({31'h0, vec_req}, 32'h0);
    apb(1'b1, ADDR_IRQ_CTRL, 32'hC0);
    take(VEC_HIGH);
    rd_chk(ADDR_IRQ_CTRL, 32'h40);
    ret_h();
    take(VEC_HIGH);
    apb(1'b1, ADDR_FLAGS, 32'hEF);
    ret_h();
    rd_chk(ADDR_IRQ_CTRL, 32'hC0);
    $display("Done: compatibility gating");
    // Pin latency: n counts from the sampling edge, read one edge late,
    // so three to four cycles of latency give n of five or six
    apb(1'b1, ADDR_ENABLES, 32'h01);
    src_event[0] <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      src_event[0] <= 1'b0;
      n++;
    end while (vec_req !== 1'b1 && n < 10);
    chk(32'(n >= 5 && n <= 6), 32'h1);
    take(VEC_HIGH);
    apb(1'b1, ADDR_FLAGS, 32'hFE);
    ret_h();
    $display("Done: pin latency");
    // Both levels at once, blocking and preemption
    apb(1'b1, ADDR_RESET_CTRL, 32'h80);
    apb(1'b1, ADDR_PRIORITY, 32'h80);
    apb(1'b1, ADDR_ENABLES, 32'hC0);
    src_event <= 8'hC0;
    @(posedge pclk);
    src_event <= 8'h00;
    take(VEC_HIGH);
    repeat (10) @(posedge pclk);
    chk({31'h0, vec_req}, 32'h0);
    apb(1'b1, ADDR_FLAGS, 32'h7F);
    ret_h();
    take(VEC_LOW);
    pulse(7);
    take(VEC_HIGH);
    chk({30'h0, in_hi, in_lo}, 32'h3);
    rd_chk(ADDR_STATUS, 32'h3);
    apb(1'b1, ADDR_FLAGS, 32'h3F);
    ret_h();
    ret_h();
    rd_chk(ADDR_IRQ_CTRL, 32'hC0);
    rd_chk(ADDR_STATUS, 32'h0);
    $display("Done: two levels");
    // Clock enable low freezes all state, so a held event goes unseen until clk_en returns
    apb(1'b1, ADDR_ENABLES, 32'h20);
    clk_en <= 1'b0;
    src_event[5] <= 1'b1;
    repeat (4) @(posedge pclk);
    chk({31'h0, vec_req}, 32'h0);
    clk_en <= 1'b1;
    @(posedge pclk);
    src_event[5] <= 1'b0;
    take(VEC_LOW);
    chk({30'h0, in_hi, in_lo}, 32'h1);
    apb(1'b1, ADDR_FLAGS, 32'hDF);
    ret_h();
    rd_chk(ADDR_IRQ_CTRL, 32'hC0);
    $display("Done: clock enable");
    // Random source and level, alternating mode, against the reference rules
    for (int i = 0; i < 12; i++) begin
      m = i % 2;
      s = $urandom % 8;
      p = $urandom % 2;
      lo = (m == 1 && p == 0);
      ack_dly <= 4'($urandom % 4);
      core_pc <= 21'($urandom);
      apb(1'b1, ADDR_RESET_CTRL, 32'(m << 7));
      apb(1'b1, ADDR_PRIORITY, 32'(p << s));
      apb(1'b1, ADDR_ENABLES, 32'(1 << s));
      pulse(s);
      take(lo ? VEC_LOW : VEC_HIGH);
      rd_chk(ADDR_IRQ_CTRL, lo ? 32'h80 : 32'h40);
      apb(1'b1, ADDR_FLAGS, ~(32'h1 << s));
      ret_h();
      rd_chk(ADDR_IRQ_CTRL, 32'hC0);
    end
    $display("Done: random sources");
    close_out();
  end
endmodule : two_level_interrupt_vectoring_test
`default_nettype wire

// *** verilog/irq_src_cell.sv ***
/*
  One interrupt source cell: sticky flag, individual enable, priority
  select and the resulting high/low request. Assumes the parent gives
  write strobes and decoded mode.
*/
`timescale 1ns/1ns
`default_nettype none
module irq_src_cell (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ce,
  input  wire logic event_in,
  input  wire logic flag_clr,
  input  wire logic flag_set_sw,
  input  wire logic en_wr,
  input  wire logic en_val,
  input  wire logic prio_wr,
  input  wire logic prio_val,
  input  wire logic prio_mode,
  output var  logic flag_reg,
  output var  logic enable_reg,
  output var  logic prio_reg,
  output wire logic req_high,
  output wire logic req_low
);
  // Flag is sticky; a new event beats a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_reg <= 1'b0;
    end else if (ce) begin
      if (event_in || flag_set_sw) begin
        flag_reg <= 1'b1;
      end else if (flag_clr) begin
        flag_reg <= 1'b0;
      end
    end
  end

  // Individual enable and priority select
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_reg <= 1'b0;
      prio_reg   <= 1'b1;
    end else if (ce) begin
      if (en_wr) begin
        enable_reg <= en_val;
      end
      if (prio_wr) begin
        prio_reg <= prio_val;
      end
    end
  end

  // Request stays asserted as long as the flag is set and enabled
  assign req_high = flag_reg && enable_reg && (prio_reg || !prio_mode);
  assign req_low  = flag_reg && enable_reg && !prio_reg && prio_mode;
endmodule : irq_src_cell
`default_nettype wire

// *** verilog/irq_vec_pkg.sv ***
/*
  Constants for the two-level interrupt vectoring block: register map,
  field positions, reset values, vector addresses and latency counts.
  Assumes a 32-bit APB master on pclk and a core sequencer alongside.
*/
package irq_vec_pkg;
  localparam int          NSRC            = 8;
  localparam int          NEXT            = 4;   // Low sources are external
  localparam int          PC_W            = 21;
  localparam logic [20:0] VEC_HIGH        = 21'h000008;
  localparam logic [20:0] VEC_LOW         = 21'h000018;
  // APB byte addresses
  localparam logic [7:0]  ADDR_IRQ_CTRL   = 8'h00;
  localparam logic [7:0]  ADDR_RESET_CTRL = 8'h04;
  localparam logic [7:0]  ADDR_FLAGS      = 8'h08;
  localparam logic [7:0]  ADDR_ENABLES    = 8'h0C;
  localparam logic [7:0]  ADDR_PRIORITY   = 8'h10;
  localparam logic [7:0]  ADDR_STATUS     = 8'h14;
  // Field positions
  localparam int          BIT_GIE_HIGH    = 7;
  localparam int          BIT_GIE_LOW     = 6;
  localparam int          BIT_PRIO_EN     = 7;
  // Reset values
  localparam logic [7:0]  RST_ENABLES     = 8'h00;
  localparam logic [7:0]  RST_PRIORITY    = 8'hFF;
  // Sync latency stages on external event inputs (plus accept stage)
  localparam int          EXT_SYNC_STAGES = 2;
endpackage : irq_vec_pkg

// *** verilog/irq_vectoring.sv ***
/*
  Two-level interrupt vectoring controller with APB register access.
  Sources 0..3 are external pins (synchronised), 4..7 are peripherals.
  The core sequencer takes vec_req with vec_addr/ret_push and answers
  vec_ack; it pulses handler_return on return from a handler.
*/
`timescale 1ns/1ns
`default_nettype none
module irq_vectoring
  import irq_vec_pkg::*;
#(
  parameter int N = NSRC
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              clk_en,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output var  logic [31:0]       prdata,
  output var  logic              pready,
  output var  logic              pslverr,
  input  wire logic [N-1:0]      src_event,
  input  wire logic [PC_W-1:0]   core_pc,
  input  wire logic              vec_ack,
  input  wire logic              handler_return,
  output var  logic              vec_req,
  output var  logic [PC_W-1:0]   vec_addr,
  output var  logic [PC_W-1:0]   ret_push,
  output var  logic              in_high_handler,
  output var  logic              in_low_handler
);
  typedef enum logic [1:0] {ST_IDLE, ST_REQ} vec_state_t;

  logic             gie_high_reg;
  logic             gie_low_reg;
  logic             prio_en_reg;
  logic [N-1:0]     flags;
  logic [N-1:0]     enables;
  logic [N-1:0]     prios;
  logic [N-1:0]     req_h;
  logic [N-1:0]     req_l;
  logic [NEXT-1:0]  ext_s1_reg;
  logic [NEXT-1:0]  ext_s2_reg;
  logic [N-1:0]     ev_in;
  logic             wr_en;
  logic             rd_en;
  logic             take_high;
  logic             take_low;
  logic             sel_high_reg;
  logic             compat_high_reg;
  vec_state_t       state_reg;
  logic [31:0]      rdata_next;
  logic             addr_ok;

  // External pin events pass two flops; peripheral events are direct
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_s1_reg <= '0;
      ext_s2_reg <= '0;
    end else if (clk_en) begin
      ext_s1_reg <= src_event[NEXT-1:0];
      ext_s2_reg <= ext_s1_reg;
    end
  end
  always_comb begin
    ev_in = src_event;
    ev_in[NEXT-1:0] = ext_s2_reg;
  end

  assign wr_en = psel && penable && pwrite && pready;
  assign rd_en = psel && !penable && !pwrite;

  // One cell per source
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_src
      irq_src_cell u_cell (
        .pclk        (pclk),
        .presetn     (presetn),
        .ce          (clk_en),
        .event_in    (ev_in[g]),
        .flag_clr    (wr_en && paddr == ADDR_FLAGS && !pwdata[g]),
        .flag_set_sw (1'b0), // Writing a one leaves a flag alone
        .en_wr       (wr_en && paddr == ADDR_ENABLES),
        .en_val      (pwdata[g]),
        .prio_wr     (wr_en && paddr == ADDR_PRIORITY),
        .prio_val    (pwdata[g]),
        .prio_mode   (prio_en_reg),
        .flag_reg    (flags[g]),
        .enable_reg  (enables[g]),
        .prio_reg    (prios[g]),
        .req_high    (req_h[g]),
        .req_low     (req_l[g])
      );
    end
  endgenerate

  // Acceptance decision; in compatibility mode bit 6 gates peripherals
  always_comb begin
    if (prio_en_reg) begin
      take_high = gie_high_reg && |req_h;
      take_low  = gie_low_reg && |req_l && !in_high_handler && !take_high;
    end else begin
      take_high = gie_high_reg &&
                  (|req_h[NEXT-1:0] ||
                   (gie_low_reg && |req_h[N-1:NEXT]));
      take_low  = 1'b0;
    end
  end

  // Vector request handshake with the core sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg       <= ST_IDLE;
      vec_req         <= 1'b0;
      vec_addr        <= '0;
      ret_push        <= '0;
      sel_high_reg    <= 1'b0;
      compat_high_reg <= 1'b0;
    end else if (clk_en) begin
      unique case (state_reg)
        ST_IDLE: begin
          if (take_high || take_low) begin
            state_reg       <= ST_REQ;
            vec_req         <= 1'b1;
            vec_addr        <= take_high ? VEC_HIGH : VEC_LOW;
            ret_push        <= core_pc;
            sel_high_reg    <= take_high;
            compat_high_reg <= !prio_en_reg;
          end
        end
        ST_REQ: begin
          if (vec_ack) begin
            state_reg <= ST_IDLE;
            vec_req   <= 1'b0;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Global enables: acceptance clears, return sets, software writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gie_high_reg <= 1'b0;
      gie_low_reg  <= 1'b0;
      prio_en_reg  <= 1'b0;
    end else if (clk_en) begin
      if (wr_en && paddr == ADDR_IRQ_CTRL) begin
        gie_high_reg <= pwdata[BIT_GIE_HIGH];
        gie_low_reg  <= pwdata[BIT_GIE_LOW];
      end
      if (wr_en && paddr == ADDR_RESET_CTRL) begin
        prio_en_reg <= pwdata[BIT_PRIO_EN];
      end
      if (handler_return) begin
        if (in_high_handler || !prio_en_reg) begin
          gie_high_reg <= 1'b1;
        end else if (in_low_handler) begin
          gie_low_reg <= 1'b1;
        end
      end
      // Acceptance last: it wins over a return in the same cycle, so it must not be lost
      if (state_reg == ST_IDLE && take_high) begin
        gie_high_reg <= 1'b0;
      end else if (state_reg == ST_IDLE && take_low) begin
        gie_low_reg <= 1'b0;
      end
    end
  end

  // Handler nesting state: high may nest over low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_high_handler <= 1'b0;
      in_low_handler  <= 1'b0;
    end else if (clk_en) begin
      if (handler_return) begin
        if (in_high_handler) begin
          in_high_handler <= 1'b0;
        end else begin
          in_low_handler <= 1'b0;
        end
      end
      // An ack beside a low return still opens the preempting handler
      if (state_reg == ST_REQ && vec_ack) begin
        if (sel_high_reg) begin
          in_high_handler <= 1'b1;
        end else begin
          in_low_handler <= 1'b1;
        end
      end
    end
  end

  // APB read mux; unmapped reads give zero with an error
  always_comb begin
    rdata_next = '0;
    addr_ok    = 1'b1;
    unique case (paddr)
      ADDR_IRQ_CTRL: begin
        rdata_next[BIT_GIE_HIGH] = gie_high_reg;
        rdata_next[BIT_GIE_LOW]  = gie_low_reg;
      end
      ADDR_RESET_CTRL: rdata_next[BIT_PRIO_EN] = prio_en_reg;
      ADDR_FLAGS:      rdata_next[N-1:0] = flags;
      ADDR_ENABLES:    rdata_next[N-1:0] = enables;
      ADDR_PRIORITY:   rdata_next[N-1:0] = prios;
      ADDR_STATUS:     rdata_next[1:0] = {in_high_handler, in_low_handler};
      default:         addr_ok = 1'b0;
    endcase
  end

  // Slave answers one cycle after setup: access phase has pready high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else if (clk_en) begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      if (rd_en) begin
        prdata <= rdata_next;
      end
    end
  end

  property p_high_first;
    @(posedge pclk) disable iff (!presetn)
      (clk_en && state_reg == ST_IDLE && take_high) |=>
        vec_req && vec_addr == VEC_HIGH;
  endproperty
  a_high_first: assert property (p_high_first)
    else $error("high request not vectored to high address");

  property p_low_vec;
    @(posedge pclk) disable iff (!presetn)
      (clk_en && state_reg == ST_IDLE && take_low) |=>
        vec_addr == VEC_LOW && !gie_low_reg;
  endproperty
  a_low_vec: assert property (p_low_vec)
    else $error("low request vector or enable clear wrong");

  property p_no_low_in_high;
    @(posedge pclk) disable iff (!presetn)
      in_high_handler |-> !take_low;
  endproperty
  a_no_low_in_high: assert property (p_no_low_in_high)
    else $error("low request taken inside high handler");

  property p_compat_single;
    @(posedge pclk) disable iff (!presetn)
      (vec_req && compat_high_reg) |-> vec_addr == VEC_HIGH;
  endproperty
  a_compat_single: assert property (p_compat_single)
    else $error("compatibility vector not single address");

  property p_clear_on_take;
    @(posedge pclk) disable iff (!presetn)
      (clk_en && state_reg == ST_IDLE && take_high) |=> !gie_high_reg;
  endproperty
  a_clear_on_take: assert property (p_clear_on_take)
    else $error("global enable not cleared on acceptance");

  property p_no_take_disabled;
    @(posedge pclk) disable iff (!presetn)
      (!gie_high_reg && prio_en_reg) |-> !take_high;
  endproperty
  a_no_take_disabled: assert property (p_no_take_disabled)
    else $error("high request taken with high enable clear");

  sequence s_ext_event;
    clk_en && src_event[0] && enables[0] && gie_high_reg &&
      !prio_en_reg && state_reg == ST_IDLE && !vec_req;
  endsequence
  property p_latency;
    @(posedge pclk) disable iff (!presetn)
      s_ext_event ##1 clk_en [*3] |-> ##[0:1] vec_req;
  endproperty
  a_latency: assert property (p_latency)
    else $error("external event latency exceeded");

  property p_prio_reset;
    @(posedge pclk) $rose(presetn) |-> !prio_en_reg;
  endproperty
  a_prio_reset: assert property (p_prio_reset)
    else $error("priority feature not clear after reset");

  // Request and its addresses stand until the core takes them
  property p_req_holds;
    @(posedge pclk) disable iff (!presetn)
      (vec_req && !vec_ack) |=>
        vec_req && $stable(vec_addr) && $stable(ret_push);
  endproperty
  a_req_holds: assert property (p_req_holds)
    else $error("vector request dropped or changed before ack");

  property p_req_drops;
    @(posedge pclk) disable iff (!presetn)
      (clk_en && vec_req && vec_ack) |=> !vec_req;
  endproperty
  a_req_drops: assert property (p_req_drops)
    else $error("vector request still high after ack");

  // A return restores the level that acceptance cleared
  sequence s_ret_high;
    clk_en && handler_return && in_high_handler &&
      !(state_reg == ST_IDLE && take_high);
  endsequence
  property p_ret_high;
    @(posedge pclk) disable iff (!presetn)
      s_ret_high |=> gie_high_reg;
  endproperty
  a_ret_high: assert property (p_ret_high)
    else $error("high enable not restored on return");

  sequence s_ret_low;
    clk_en && handler_return && prio_en_reg && !in_high_handler &&
      in_low_handler && !(state_reg == ST_IDLE && take_low);
  endsequence
  property p_ret_low;
    @(posedge pclk) disable iff (!presetn)
      s_ret_low |=> gie_low_reg;
  endproperty
  a_ret_low: assert property (p_ret_low)
    else $error("low enable not restored on return");

  // Flags follow their events whatever the enables say
  property p_flag_sets;
    @(posedge pclk) disable iff (!presetn)
      (clk_en && ev_in != '0) |=> (flags & $past(ev_in)) == $past(ev_in);
  endproperty
  a_flag_sets: assert property (p_flag_sets)
    else $error("event did not set its flag");

  property p_compat_gate;
    @(posedge pclk) disable iff (!presetn)
      (!prio_en_reg && !gie_low_reg && req_h[NEXT-1:0] == '0) |->
        !take_high;
  endproperty
  a_compat_gate: assert property (p_compat_gate)
    else $error("peripheral taken with peripheral group disabled");

  property p_preempt;
    @(posedge pclk) disable iff (!presetn)
      (clk_en && state_reg == ST_IDLE && prio_en_reg && in_low_handler &&
       gie_high_reg && |req_h) |=> vec_req && vec_addr == VEC_HIGH;
  endproperty
  a_preempt: assert property (p_preempt)
    else $error("high request did not preempt low handler");
endmodule : irq_vectoring
`default_nettype wire
